// ==== verilog/emi_map.vh ====
// Constants for the external memory interface: modes, field positions and timing.
`ifndef EMI_MAP_VH
`define EMI_MAP_VH

// Memory-mode field values.
`define EMI_MODE_ONCHIP 2'h0
`define EMI_MODE_SPLIT 2'h1
`define EMI_MODE_SPLIT_BANK 2'h2
`define EMI_MODE_OFFCHIP 2'h3

// Configuration word field positions.
`define EMI_CFG_MUX_BIT 4
`define EMI_CFG_MODE_HI 3
`define EMI_CFG_MODE_LO 2
`define EMI_CFG_ALE_HI 1
`define EMI_CFG_ALE_LO 0

// Timing register field positions and reset value.
`define EMI_TC_SETUP_HI 7
`define EMI_TC_SETUP_LO 6
`define EMI_TC_STROBE_HI 5
`define EMI_TC_STROBE_LO 2
`define EMI_TC_HOLD_HI 1
`define EMI_TC_HOLD_LO 0
`define EMI_TC_RESET 8'hFF

// On-chip data RAM.
`define EMI_RAM_AW 9
`define EMI_RAM_DEPTH 512
`define EMI_RAM_BOUNDARY 16'h0200

// Control pin bit positions and control pin count.
`define EMI_CTL_RD_N 0
`define EMI_CTL_WR_N 1
`define EMI_CTL_ALE 2
`define EMI_CTL_W 3

`endif

// ==== verilog/emi_xdata_ram.v ====
// On-chip data RAM with registered read data.
`timescale 1ns/100ps
module emi_xdata_ram
(
    input wire clk_i,
    input wire en_i,
    input wire we_i,
    input wire [8:0] addr_i,
    input wire [7:0] wdata_i,
    output reg [7:0] rdata_o
);
    reg [7:0] mem [0:511];

    always @(posedge clk_i)
    begin
        if (en_i)
        begin
            if (we_i)
            begin
                mem[addr_i] <= wdata_i;
            end
            rdata_o <= mem[addr_i];
        end
    end
endmodule

// ==== verilog/emi_pin_mux.v ====
// Per-bit choice between port latch and interface drive for one port group.
`timescale 1ns/100ps
module emi_pin_mux
#(
    parameter W = 8
)
(
    input wire clk_i,
    input wire srst_i,
    input wire claim_i,
    input wire [W-1:0] drive_i,
    input wire [W-1:0] val_i,
    input wire [W-1:0] latch_i,
    input wire [W-1:0] push_pull_i,
    output reg [W-1:0] pin_o,
    output reg [W-1:0] pin_oe_o
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            wire v;
            wire d;
            // Outside a claim the latch owns the pin.
            assign v = claim_i ? val_i[i] : latch_i[i];
            assign d = claim_i ? drive_i[i] : 1'b1;
            always @(posedge clk_i)
            begin
                if (srst_i)
                begin
                    pin_o[i] <= 1'b1;
                    pin_oe_o[i] <= 1'b0;
                end
                else
                begin
                    pin_o[i] <= v;
                    // Open-drain pins only pull low; the mode bit is never touched here.
                    pin_oe_o[i] <= d & (push_pull_i[i] | ~v);
                end
            end
        end
    endgenerate
endmodule

// ==== verilog/emi_ext_mem_if.v ====
// External-data move router: on-chip RAM or off-chip parallel bus on port pins.
`timescale 1ns/100ps
`include "emi_map.vh"
// How it works
// - Claim port pins only during off-chip moves.
// - Disable drivers of claimed pins used as inputs.
// - Leave open-drain or push-pull choice untouched.
// - Multiplexed option and four memory modes.
// - Split bank mode: below boundary goes on-chip.
// - Eight-bit moves decide by bank register.
// - Split bank eight-bit off-chip: bank high, pointer low.
// - Sixteen-bit moves decide and drive by pointer.
// - Off-chip-only mode hides on-chip RAM.
// - Off-chip-only eight-bit: upper lines undriven.
// - Off-chip-only sixteen-bit drives all lines.
// - Off-chip move lasts timing plus five cycles.
// - Multiplexed latch strobe adds two cycles minimum.
// - Timing register resets to maximum delays.
module emi_ext_mem_if
(
    input wire clk_i,
    input wire srst_i,
    input wire req_i,
    input wire req_write_i,
    input wire req_wide_i,
    input wire req_sel_b_i,
    input wire [15:0] data_pointer_i,
    input wire [7:0] indirect_pointer_a_i,
    input wire [7:0] indirect_pointer_b_i,
    input wire [7:0] wdata_i,
    input wire [4:0] ext_mem_config_i,
    input wire [7:0] ext_mem_bank_reg_i,
    input wire timing_we_i,
    input wire [7:0] timing_wdata_i,
    input wire [7:0] latch_addr_hi_i,
    input wire [7:0] latch_addr_lo_i,
    input wire [7:0] latch_data_i,
    input wire [2:0] latch_ctl_i,
    input wire [7:0] mode_addr_hi_i,
    input wire [7:0] mode_addr_lo_i,
    input wire [7:0] mode_data_i,
    input wire [2:0] mode_ctl_i,
    input wire [7:0] data_pin_i,
    output wire busy_o,
    output reg done_o,
    output reg [7:0] rdata_o,
    output wire [7:0] ext_mem_timing_o,
    output wire [7:0] addr_hi_o,
    output wire [7:0] addr_hi_oe_o,
    output wire [7:0] addr_lo_o,
    output wire [7:0] addr_lo_oe_o,
    output wire [7:0] data_o,
    output wire [7:0] data_oe_o,
    output wire [2:0] ctl_o,
    output wire [2:0] ctl_oe_o
);
    localparam [8:0] S_IDLE = 9'h001;
    localparam [8:0] S_ONCHIP = 9'h002;
    localparam [8:0] S_START = 9'h004;
    localparam [8:0] S_ALE = 9'h008;
    localparam [8:0] S_SETUP = 9'h010;
    localparam [8:0] S_STROBE = 9'h020;
    localparam [8:0] S_HOLD = 9'h040;
    localparam [8:0] S_END = 9'h080;
    localparam [8:0] S_DONE = 9'h100;

    reg [8:0] state_reg;
    reg [8:0] state_next;
    reg [3:0] cnt_reg;
    reg [3:0] cnt_next;
    reg [7:0] timing_reg;
    reg [15:0] addr_reg;
    reg [7:0] wdata_reg;
    reg write_reg;
    reg onchip_reg;
    reg hi_drive_reg;
    reg mux_reg;

    wire [1:0] mode;
    wire mux_cfg;
    wire [1:0] ale_w;
    wire [1:0] setup_w;
    wire [3:0] strobe_w;
    wire [1:0] hold_w;
    wire [7:0] ptr8;
    wire [15:0] addr8;
    wire [15:0] eff_addr;
    wire below;
    reg hit;
    reg hi_drive;
    reg rd_last_reg;
    wire [7:0] ram_rdata;

    assign mode = ext_mem_config_i[`EMI_CFG_MODE_HI:`EMI_CFG_MODE_LO];
    assign mux_cfg = ext_mem_config_i[`EMI_CFG_MUX_BIT];
    assign ale_w = ext_mem_config_i[`EMI_CFG_ALE_HI:`EMI_CFG_ALE_LO];
    assign setup_w = timing_reg[`EMI_TC_SETUP_HI:`EMI_TC_SETUP_LO];
    assign strobe_w = timing_reg[`EMI_TC_STROBE_HI:`EMI_TC_STROBE_LO];
    assign hold_w = timing_reg[`EMI_TC_HOLD_HI:`EMI_TC_HOLD_LO];
    assign ext_mem_timing_o = timing_reg;
    assign busy_o = ~state_reg[0];

    // The bank register supplies the upper byte of an eight-bit move.
    assign ptr8 = req_sel_b_i ? indirect_pointer_b_i : indirect_pointer_a_i;
    assign addr8 = {ext_mem_bank_reg_i, ptr8};
    assign eff_addr = req_wide_i ? data_pointer_i : addr8;
    assign below = eff_addr < `EMI_RAM_BOUNDARY;

    // Route decision and upper-byte drive for the request now offered.
    always @*
    begin
        hit = 1'b0;
        hi_drive = 1'b1;
        case (mode)
            `EMI_MODE_ONCHIP:
            begin
                hit = 1'b1;
            end
            `EMI_MODE_SPLIT:
            begin
                hit = below;
                hi_drive = req_wide_i;
            end
            `EMI_MODE_SPLIT_BANK:
            begin
                hit = below;
                hi_drive = 1'b1;
            end
            default:
            begin
                hit = 1'b0;
                hi_drive = req_wide_i;
            end
        endcase
    end

    // Timing register: maximum delays after reset so slow parts work first time.
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            timing_reg <= `EMI_TC_RESET;
        end
        else if (timing_we_i && state_reg[0])
        begin
            timing_reg <= timing_wdata_i;
        end
    end

    // Each off-chip phase loads its length minus one into the counter.
    always @*
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            S_IDLE:
            begin
                if (req_i)
                begin
                    state_next = hit ? S_ONCHIP : S_START;
                end
            end
            S_ONCHIP:
            begin
                state_next = S_DONE;
            end
            S_START:
            begin
                if (mux_reg)
                begin
                    state_next = S_ALE;
                    cnt_next = {2'h0, ale_w} + 4'h1;
                end
                else if (setup_w != 2'h0)
                begin
                    state_next = S_SETUP;
                    cnt_next = {2'h0, setup_w} - 4'h1;
                end
                else
                begin
                    state_next = S_STROBE;
                    cnt_next = strobe_w;
                end
            end
            S_ALE:
            begin
                if (cnt_reg != 4'h0)
                begin
                    cnt_next = cnt_reg - 4'h1;
                end
                else if (setup_w != 2'h0)
                begin
                    state_next = S_SETUP;
                    cnt_next = {2'h0, setup_w} - 4'h1;
                end
                else
                begin
                    state_next = S_STROBE;
                    cnt_next = strobe_w;
                end
            end
            S_SETUP:
            begin
                if (cnt_reg != 4'h0)
                begin
                    cnt_next = cnt_reg - 4'h1;
                end
                else
                begin
                    state_next = S_STROBE;
                    cnt_next = strobe_w;
                end
            end
            S_STROBE:
            begin
                if (cnt_reg != 4'h0)
                begin
                    cnt_next = cnt_reg - 4'h1;
                end
                else if (hold_w != 2'h0)
                begin
                    state_next = S_HOLD;
                    cnt_next = {2'h0, hold_w} - 4'h1;
                end
                else
                begin
                    state_next = S_END;
                    cnt_next = 4'h1;
                end
            end
            S_HOLD:
            begin
                if (cnt_reg != 4'h0)
                begin
                    cnt_next = cnt_reg - 4'h1;
                end
                else
                begin
                    state_next = S_END;
                    cnt_next = 4'h1;
                end
            end
            S_END:
            begin
                // Start, the extra strobe cycle, two end cycles and done make the five fixed cycles.
                if (cnt_reg != 4'h0)
                begin
                    cnt_next = cnt_reg - 4'h1;
                end
                else
                begin
                    state_next = S_DONE;
                end
            end
            S_DONE:
            begin
                state_next = S_IDLE;
            end
            default:
            begin
                state_next = S_IDLE;
                cnt_next = 4'h0;
            end
        endcase
    end

    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_reg <= S_IDLE;
            cnt_reg <= 4'h0;
            addr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
            write_reg <= 1'b0;
            onchip_reg <= 1'b0;
            hi_drive_reg <= 1'b0;
            mux_reg <= 1'b0;
            rd_last_reg <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            done_o <= (state_next == S_DONE);
            if (state_reg[0] && req_i)
            begin
                addr_reg <= eff_addr;
                wdata_reg <= wdata_i;
                write_reg <= req_write_i;
                onchip_reg <= hit;
                hi_drive_reg <= hi_drive;
                mux_reg <= mux_cfg;
            end
            // The strobe on the pins lags the state by one register, so the byte is taken
            // one edge after the last strobe state, while the pin strobe is still low.
            rd_last_reg <= (state_reg == S_STROBE) && (cnt_reg == 4'h0) && !write_reg;
            if (rd_last_reg)
            begin
                rdata_o <= data_pin_i;
            end
            if (state_reg == S_DONE && onchip_reg && !write_reg)
            begin
                rdata_o <= ram_rdata;
            end
        end
    end

    emi_xdata_ram u_ram
    (
        .clk_i(clk_i),
        .en_i(state_reg == S_ONCHIP),
        .we_i(write_reg),
        .addr_i(addr_reg[`EMI_RAM_AW-1:0]),
        .wdata_i(wdata_reg),
        .rdata_o(ram_rdata)
    );

    // Pin drive values while a move owns the bus.
    wire claim;
    wire addr_phase;
    wire data_drive;
    wire [2:0] ctl_val;
    wire [7:0] data_val;

    assign claim = ~state_reg[0] && ~onchip_reg && state_reg != S_ONCHIP
        && state_reg != S_DONE;
    assign addr_phase = (state_reg == S_START) || (state_reg == S_ALE);
    assign data_drive = mux_reg && addr_phase ? 1'b1 : write_reg;
    assign data_val = mux_reg && addr_phase ? addr_reg[7:0] : wdata_reg;
    assign ctl_val[`EMI_CTL_RD_N] = ~(state_reg == S_STROBE && !write_reg);
    assign ctl_val[`EMI_CTL_WR_N] = ~(state_reg == S_STROBE && write_reg);
    assign ctl_val[`EMI_CTL_ALE] = (state_reg == S_ALE) && (cnt_reg != 4'h0);

    emi_pin_mux #(.W(8)) u_hi
    (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .claim_i(claim && hi_drive_reg),
        .drive_i({8{1'b1}}),
        .val_i(addr_reg[15:8]),
        .latch_i(latch_addr_hi_i),
        .push_pull_i(mode_addr_hi_i),
        .pin_o(addr_hi_o),
        .pin_oe_o(addr_hi_oe_o)
    );

    // The multiplexed bus carries the low address on the data pins instead.
    emi_pin_mux #(.W(8)) u_lo
    (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .claim_i(claim && !mux_reg),
        .drive_i({8{1'b1}}),
        .val_i(addr_reg[7:0]),
        .latch_i(latch_addr_lo_i),
        .push_pull_i(mode_addr_lo_i),
        .pin_o(addr_lo_o),
        .pin_oe_o(addr_lo_oe_o)
    );

    emi_pin_mux #(.W(8)) u_data
    (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .claim_i(claim),
        .drive_i({8{data_drive}}),
        .val_i(data_val),
        .latch_i(latch_data_i),
        .push_pull_i(mode_data_i),
        .pin_o(data_o),
        .pin_oe_o(data_oe_o)
    );

    emi_pin_mux #(.W(`EMI_CTL_W)) u_ctl
    (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .claim_i(claim),
        .drive_i({`EMI_CTL_W{1'b1}}),
        .val_i(ctl_val),
        .latch_i(latch_ctl_i),
        .push_pull_i(mode_ctl_i),
        .pin_o(ctl_o),
        .pin_oe_o(ctl_oe_o)
    );
endmodule

// ==== verif/emi_mem_model.sv ====
// Behavioural off-chip byte memory hanging on the parallel bus pins.
`timescale 1ns/100ps
module emi_mem_model
(
    input wire clk_i,
    input wire mux_i,
    input wire [15:0] addr_i,
    input wire [7:0] bus_i,
    input wire [2:0] ctl_i,
    output wire [7:0] drive_o,
    output reg [15:0] last_addr_o,
    output reg [31:0] strobes_o
);
    reg [7:0] mem [0:65535];
    reg [7:0] alat;
    reg [7:0] last_q;
    reg [2:0] ctl_q;
    integer k;
    wire [15:0] adr = {addr_i[15:8], mux_i ? alat : addr_i[7:0]};
    // A released bus shows the inverse of the last byte, so a stale read cannot pass.
    assign drive_o = ctl_i[0] ? ~last_q : mem[adr];
    initial
    begin
        strobes_o = 32'h0;
        last_addr_o = 16'h0;
        alat = 8'h00;
        last_q = 8'h00;
        ctl_q = 3'h7;
        for (k = 0; k < 65536; k = k + 1)
            mem[k] = k[15:8] ^ k[7:0];
    end
    always @(posedge clk_i)
    begin
        ctl_q <= ctl_i;
        if (ctl_i[2])
            alat <= bus_i;
        if (!ctl_i[0])
            last_q <= mem[adr];
        if (!ctl_i[1])
            mem[adr] <= bus_i;
        if ((ctl_q[0] && !ctl_i[0]) || (ctl_q[1] && !ctl_i[1]))
        begin
            strobes_o <= strobes_o + 32'h1;
            last_addr_o <= adr;
        end
    end
endmodule

// ==== verif/emi_ext_mem_if_monitor.sv ====
// Port-level checker for the external memory interface router.
`timescale 1ns/100ps
module emi_ext_mem_if_monitor
(
    input wire clk_i,
    input wire srst_i,
    input wire req_i,
    input wire [4:0] ext_mem_config_i,
    input wire timing_we_i,
    input wire [7:0] timing_wdata_i,
    input wire [2:0] latch_ctl_i,
    input wire [2:0] mode_ctl_i,
    input wire busy_o,
    input wire done_o,
    input wire [7:0] ext_mem_timing_o,
    input wire [7:0] data_oe_o,
    input wire [2:0] ctl_o,
    input wire [2:0] ctl_oe_o
);
    reg off_q;
    reg [5:0] cyc_q;
    reg [5:0] exp_q;
    wire [7:0] t = ext_mem_timing_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    always @(posedge clk_i)
    begin
        cyc_q <= (req_i && !busy_o) ? 6'h01 : cyc_q + 6'h01;
        if (srst_i || done_o)
            off_q <= 1'b0;
        else if (req_i && !busy_o)
        begin
            off_q <= (ext_mem_config_i[3:2] == 2'h3);
            exp_q <= {4'h0, t[7:6]} + {2'h0, t[5:2]} + {4'h0, t[1:0]} + 6'h05
                + (ext_mem_config_i[4] ? {4'h0, ext_mem_config_i[1:0]} + 6'h02 : 6'h00);
        end
    end
    a_reset_timing: assert property ($fell(srst_i) |-> t == 8'hFF)
        else $error("timing register not at maximum after reset");
    a_busy_follows: assert property (req_i && !busy_o |=> busy_o)
        else $error("busy did not follow an accepted request");
    a_done_single: assert property (done_o |=> !done_o)
        else $error("done lasted more than one cycle");
    a_off_latency: assert property (off_q && done_o |-> cyc_q == exp_q)
        else $error("off-chip move length differs from programmed timing");
    a_off_bound: assert property (off_q |-> cyc_q <= exp_q)
        else $error("off-chip move overran its programmed length");
    a_read_released: assert property (ctl_oe_o[0] && !ctl_o[0] |-> data_oe_o == 8'h00)
        else $error("data pins driven during a read strobe");
    a_od_kept: assert property ((~mode_ctl_i & ctl_o & ctl_oe_o) == 3'h0)
        else $error("open-drain control pin actively driven high");
    a_pins_return: assert property (done_o |=> ctl_o == $past(latch_ctl_i)
        && ctl_oe_o == ($past(mode_ctl_i) | ~$past(latch_ctl_i)))
        else $error("control pins not back on port latches after a move");
    a_timing_refused: assert property (busy_o && timing_we_i |=> $stable(t))
        else $error("timing register changed during a move");
    a_timing_write: assert property (timing_we_i && !busy_o |=> t == $past(timing_wdata_i))
        else $error("timing register write lost");
    c_off_done: cover property (off_q && done_o);
    c_on_take: cover property (req_i && !busy_o && ext_mem_config_i[3:2] == 2'h0);
    c_ale_seen: cover property (ctl_oe_o[2] && ctl_o[2]);
endmodule

bind emi_ext_mem_if emi_ext_mem_if_monitor mon_u (.*);

// ==== verif/emi_ext_mem_if_bench.sv ====
// Directed bench for the external memory interface router.
`timescale 1ns/100ps
module emi_ext_mem_if_bench;
    reg clk_i, srst_i, req_i, req_write_i, req_wide_i, req_sel_b_i, timing_we_i, poke;
    reg [15:0] data_pointer_i;
    reg [7:0] indirect_pointer_a_i, indirect_pointer_b_i, wdata_i, ext_mem_bank_reg_i;
    reg [7:0] timing_wdata_i, latch_addr_hi_i, latch_addr_lo_i, latch_data_i;
    reg [7:0] mode_addr_hi_i, mode_addr_lo_i, mode_data_i;
    reg [4:0] ext_mem_config_i;
    reg [2:0] latch_ctl_i, mode_ctl_i;
    wire [7:0] data_pin_i, rdata_o, ext_mem_timing_o, addr_hi_o, addr_hi_oe_o, addr_lo_o;
    wire [7:0] addr_lo_oe_o, data_o, data_oe_o, mdl_d;
    wire [2:0] ctl_o, ctl_oe_o;
    wire busy_o, done_o;
    wire [15:0] mdl_adr;
    wire [31:0] strobes;
    integer failures, samples_checked, lat, hi_chg, pin_chg, p0, h0, s0;
    // Data lines that the block releases carry whatever the far-side model shows.
    assign data_pin_i = (data_o & data_oe_o) | (mdl_d & ~data_oe_o);
    emi_ext_mem_if dut_u (.*);
    emi_mem_model mdl_u (.clk_i(clk_i), .mux_i(ext_mem_config_i[4]),
        .addr_i({addr_hi_o | ~addr_hi_oe_o, addr_lo_o | ~addr_lo_oe_o}), .bus_i(data_pin_i),
        .ctl_i(ctl_o | ~ctl_oe_o), .drive_o(mdl_d), .last_addr_o(mdl_adr), .strobes_o(strobes));
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // Sampled on the falling edge so registered pin updates have settled.
    always @(negedge clk_i)
    begin
        if ({addr_hi_o, addr_hi_oe_o} !== {latch_addr_hi_i, mode_addr_hi_i | ~latch_addr_hi_i})
            hi_chg = hi_chg + 1;
        if ({addr_lo_o, addr_lo_oe_o, data_o, ctl_o, ctl_oe_o, data_oe_o} !==
            {latch_addr_lo_i, mode_addr_lo_i | ~latch_addr_lo_i, latch_data_i, latch_ctl_i,
            mode_ctl_i | ~latch_ctl_i, mode_data_i | ~latch_data_i})
            pin_chg = pin_chg + 1;
    end
    task summarize;
    begin
        if (failures == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    // An 8-bit move takes its upper byte from the bank and its lower byte from a pointer.
    task move(input [4:0] cfg, input [2:0] kind, input [15:0] adr, input [7:0] wd);
    begin
        @(posedge clk_i);
        ext_mem_config_i <= cfg;
        {req_write_i, req_wide_i, req_sel_b_i} <= kind;
        data_pointer_i <= adr;
        ext_mem_bank_reg_i <= adr[15:8];
        indirect_pointer_a_i <= kind[0] ? ~adr[7:0] : adr[7:0];
        indirect_pointer_b_i <= kind[0] ? adr[7:0] : ~adr[7:0];
        wdata_i <= wd;
        req_i <= 1'b1;
        @(posedge clk_i);
        req_i <= 1'b0;
        timing_we_i <= poke;
        timing_wdata_i <= 8'hFF;
        #1;
        lat = 1;
        while (done_o !== 1'b1 && lat < 60)
        begin
            @(posedge clk_i);
            timing_we_i <= 1'b0;
            #1;
            lat = lat + 1;
        end
        if (lat >= 60)
        begin
            failures = failures + 1;
            summarize;
        end
        // On-chip read data lands one edge after done; the pins return to the latches then.
        @(posedge clk_i);
        #1;
    end
    endtask
    initial
    begin
        failures = 0;
        samples_checked = 0;
        hi_chg = 0;
        pin_chg = 0;
        poke = 1'b0;
        {srst_i, req_i, req_write_i, req_wide_i, req_sel_b_i, timing_we_i} = 6'h20;
        data_pointer_i = 16'h0000;
        {indirect_pointer_a_i, indirect_pointer_b_i, wdata_i, ext_mem_bank_reg_i} = 32'h0;
        {timing_wdata_i, ext_mem_config_i} = 13'h0;
        latch_addr_hi_i = 8'h5A;
        latch_addr_lo_i = 8'hC3;
        latch_data_i = 8'hFF;
        latch_ctl_i = 3'h7;
        mode_addr_hi_i = 8'h0F;
        mode_addr_lo_i = 8'hFF;
        mode_data_i = 8'hFF;
        mode_ctl_i = 3'h5;
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check(ext_mem_timing_o, 8'hFF);
        check({busy_o, done_o}, 2'h0);
        move(5'h0C, 3'b110, 16'h0010, 8'h3C);
        check(lat, 26);
        check(mdl_adr, 16'h0010);
        @(posedge clk_i);
        timing_wdata_i <= 8'h00;
        timing_we_i <= 1'b1;
        @(posedge clk_i);
        timing_we_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check(ext_mem_timing_o, 8'h00);
        move(5'h0C, 3'b010, 16'h0010, 8'h00);
        check(lat, 5);
        check(rdata_o, 8'h3C);
        h0 = hi_chg;
        move(5'h0C, 3'b001, 16'h7721, 8'h00);
        check(mdl_adr, 16'h5A21);
        check(hi_chg - h0, 0);
        check(rdata_o, 8'h7B);
        p0 = pin_chg;
        s0 = strobes;
        move(5'h00, 3'b110, 16'h01FF, 8'hA5);
        move(5'h08, 3'b100, 16'h0180, 8'h66);
        move(5'h08, 3'b010, 16'h01FF, 8'h00);
        check(rdata_o, 8'hA5);
        move(5'h08, 3'b000, 16'h0180, 8'h00);
        check(rdata_o, 8'h66);
        check(strobes - s0, 0);
        check(pin_chg - p0, 0);
        move(5'h08, 3'b101, 16'h1234, 8'h44);
        check(mdl_adr, 16'h1234);
        move(5'h08, 3'b010, 16'h0200, 8'h00);
        check({mdl_adr, rdata_o}, 24'h020002);
        move(5'h0C, 3'b010, 16'h01FF, 8'h00);
        check(rdata_o, 8'hFE);
        move(5'h04, 3'b010, 16'h1234, 8'h00);
        check(rdata_o, 8'h44);
        move(5'h1C, 3'b110, 16'hABCD, 8'h5E);
        check(lat, 7);
        move(5'h1C, 3'b010, 16'hABCD, 8'h00);
        check({mdl_adr, rdata_o}, 24'hABCD5E);
        @(posedge clk_i);
        latch_addr_hi_i <= 8'hA5;
        mode_addr_hi_i <= 8'hF0;
        latch_ctl_i <= 3'h3;
        poke = 1'b1;
        move(5'h0C, 3'b000, 16'h0042, 8'h00);
        check({mdl_adr, rdata_o}, 24'hA542E7);
        check(lat, 5);
        check(ext_mem_timing_o, 8'h00);
        @(posedge clk_i);
        srst_i <= 1'b1;
        @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check(ext_mem_timing_o, 8'hFF);
        check({ctl_o, rdata_o}, 11'h300);
        summarize;
    end
endmodule
